// >>> include/pfc_map.vh
`ifndef PFC_MAP_VH
`define PFC_MAP_VH
// software register word indices
`define PFC_REG_CTRL 4'h0
`define PFC_REG_ADDR 4'h1
`define PFC_REG_WDATA 4'h2
`define PFC_REG_RDATA 4'h3
`define PFC_REG_STAT 4'h4
`define PFC_REG_SECT 4'h5
// command codes written to CTRL[3:0]
`define PFC_CMD_READ 4'h1
`define PFC_CMD_WRITE 4'h2
`define PFC_CMD_RESET 4'h3
`define PFC_CMD_CHIP_ERASE 4'h4
`define PFC_CMD_SECT_ERASE 4'h5
`define PFC_CMD_ONE_STROBE 4'h6
// control register fields
`define PFC_CTRL_WIDTH_BIT 8
`define PFC_CTRL_GUARD_BIT 9
// status fields
`define PFC_STAT_BUSY_BIT 0
`define PFC_STAT_ONE_STROBE_BIT 1
`define PFC_STAT_ERASING_BIT 2
`define PFC_STAT_REFUSED_BIT 3
// bus timing, cycles at 10 MHz
`define PFC_CLK_HZ 10000000
`define PFC_RESET_LOW_NS 500
`define PFC_PHASE_CYC 4'h2
// device facts
`define PFC_SECTOR_COUNT 71
`define PFC_ERASE_CODE 8'h30
`define PFC_POLL_BIT 7
`endif

// >>> src/pfc_seq_rom.v
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.vh"
// command preamble table: address and data of each bus cycle
module pfc_seq_rom (
  // select
  input wire [3:0] cmd_i,
  input wire [2:0] step_i,
  // table entry
  output reg [20:0] addr_o,
  output reg [7:0] data_o,
  output reg [2:0] len_o
);
  always @* begin
    addr_o = 21'h000555;
    data_o = 8'hAA;
    len_o = 3'h0;
    case (cmd_i)
      `PFC_CMD_WRITE: len_o = 3'h4;
      `PFC_CMD_CHIP_ERASE: len_o = 3'h6;
      `PFC_CMD_SECT_ERASE: len_o = 3'h6;
      `PFC_CMD_ONE_STROBE: len_o = 3'h6;
      default: len_o = 3'h0;
    endcase
    case (step_i)
      3'h0: begin
        addr_o = 21'h000555;
        data_o = 8'hAA;
      end
      3'h1: begin
        addr_o = 21'h0002AA;
        data_o = 8'h55;
      end
      3'h2: begin
        addr_o = 21'h000555;
        data_o = (cmd_i == `PFC_CMD_WRITE) ? 8'hA0 : 8'h80;
      end
      3'h3: begin
        addr_o = 21'h000555;
        data_o = 8'hAA;
      end
      3'h4: begin
        addr_o = 21'h0002AA;
        data_o = 8'h55;
      end
      default: begin
        addr_o = 21'h000555;
        data_o = (cmd_i == `PFC_CMD_CHIP_ERASE) ? 8'h10 :
                 (cmd_i == `PFC_CMD_SECT_ERASE) ? `PFC_ERASE_CODE : 8'hA0;
      end
    endcase
  end
endmodule // pfc_seq_rom
`default_nettype wire

// >>> src/pfc_ctrl.v
`timescale 1ns/1ps
`default_nettype none
// How it works
// - after the six-cycle entry, each single strobe programs one location.
// - one-strobe mode ends only by reset held low 500 ns then released.
// - each command cycle pulses write strobe low with select low, drive high.
// - erased bits read one; host erases before reprogramming (the write command does not erase; a second write ANDs into the old data).
// - sector erase is six cycles; sector address and 30H on the sixth.
`include "pfc_map.vh"
module pfc_ctrl (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // software port
  input wire [3:0] sw_addr_i,
  input wire [31:0] sw_wdata_i,
  input wire sw_we_i,
  input wire sw_re_i,
  output reg [31:0] sw_rdata_o,
  // flash pins
  output reg [20:0] fl_addr_o,
  input wire [15:0] fl_dq_i,
  output reg [15:0] fl_dq_o,
  output reg fl_dq_oe_o,
  output reg fl_ce_n_o,
  output reg fl_oe_n_o,
  output reg fl_we_n_o,
  output reg fl_reset_n_o,
  output reg fl_byte_o,
  output reg fl_vpp_en_o
);
  localparam integer RESET_CYC_I = (`PFC_RESET_LOW_NS * (`PFC_CLK_HZ / 1000000) + 999) / 1000;
  localparam [7:0] RESET_CYC = RESET_CYC_I[7:0];
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_SETUP = 7'h02;
  localparam [6:0] S_STROBE = 7'h04;
  localparam [6:0] S_HOLD = 7'h08;
  localparam [6:0] S_READ = 7'h10;
  localparam [6:0] S_RESET = 7'h20;
  localparam [6:0] S_POLL = 7'h40;

  reg [6:0] state_reg;
  reg [3:0] cmd_reg;
  reg [2:0] step_reg;
  reg [3:0] phase_reg;
  reg [7:0] rst_cnt_reg;
  reg [20:0] addr_reg;
  reg [15:0] wdata_reg;
  reg [15:0] rdata_reg;
  reg [6:0] sect_reg;
  reg width_reg;
  reg guard_reg;
  reg one_strobe_reg;
  reg erasing_reg;
  reg refused_reg;
  reg [15:0] dq_s1_reg;
  reg [15:0] dq_s2_reg;
  wire [20:0] rom_addr;
  wire [7:0] rom_data;
  wire [2:0] rom_len;
  wire busy;

  function [15:0] fit_width;
    input [15:0] d;
    input wide;
    begin
      fit_width = wide ? d : {8'h00, d[7:0]};
    end
  endfunction

  pfc_seq_rom u_rom (
    .cmd_i(cmd_reg),
    .step_i(step_reg),
    .addr_o(rom_addr),
    .data_o(rom_data),
    .len_o(rom_len)
  );

  assign busy = (state_reg != S_IDLE);

  // pin synchroniser
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
    end else begin
      dq_s1_reg <= fl_dq_i;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // software read port
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sw_rdata_o <= 32'h00000000;
    end else if (sw_re_i) begin
      case (sw_addr_i)
        `PFC_REG_CTRL: sw_rdata_o <= {22'h000000, guard_reg, width_reg, 4'h0, cmd_reg};
        `PFC_REG_ADDR: sw_rdata_o <= {11'h000, addr_reg};
        `PFC_REG_WDATA: sw_rdata_o <= {16'h0000, wdata_reg};
        `PFC_REG_RDATA: sw_rdata_o <= {16'h0000, rdata_reg};
        `PFC_REG_STAT: sw_rdata_o <= {28'h0000000, refused_reg, erasing_reg, one_strobe_reg, busy};
        `PFC_REG_SECT: sw_rdata_o <= {25'h0000000, sect_reg};
        default: sw_rdata_o <= 32'h00000000;
      endcase
    end else begin
      sw_rdata_o <= 32'h00000000;
    end
  end

  // main sequencer
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= S_IDLE;
      cmd_reg <= 4'h0;
      step_reg <= 3'h0;
      phase_reg <= 4'h0;
      rst_cnt_reg <= 8'h00;
      addr_reg <= 21'h000000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      sect_reg <= 7'h00;
      width_reg <= 1'b1;
      guard_reg <= 1'b0;
      one_strobe_reg <= 1'b0;
      erasing_reg <= 1'b0;
      refused_reg <= 1'b0;
      fl_addr_o <= 21'h000000;
      fl_dq_o <= 16'h0000;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o <= 1'b1;
      fl_oe_n_o <= 1'b1;
      fl_we_n_o <= 1'b1;
      fl_reset_n_o <= 1'b0;
      fl_byte_o <= 1'b1;
      fl_vpp_en_o <= 1'b0;
    end else begin
      fl_reset_n_o <= (state_reg != S_RESET);
      fl_byte_o <= width_reg;
      fl_vpp_en_o <= guard_reg;
      if (sw_we_i && sw_addr_i == `PFC_REG_ADDR) addr_reg <= sw_wdata_i[20:0];
      if (sw_we_i && sw_addr_i == `PFC_REG_WDATA) wdata_reg <= sw_wdata_i[15:0];
      if (sw_we_i && sw_addr_i == `PFC_REG_SECT && sw_wdata_i[6:0] < `PFC_SECTOR_COUNT)
        sect_reg <= sw_wdata_i[6:0];
      case (state_reg)
        S_IDLE: begin
          fl_ce_n_o <= 1'b1;
          fl_oe_n_o <= 1'b1;
          fl_we_n_o <= 1'b1;
          fl_dq_oe_o <= 1'b0;
          if (sw_we_i && sw_addr_i == `PFC_REG_CTRL) begin
            width_reg <= sw_wdata_i[`PFC_CTRL_WIDTH_BIT];
            guard_reg <= sw_wdata_i[`PFC_CTRL_GUARD_BIT];
            cmd_reg <= sw_wdata_i[3:0];
            step_reg <= 3'h0;
            phase_reg <= 4'h0;
            refused_reg <= 1'b0;
            case (sw_wdata_i[3:0])
              `PFC_CMD_READ: state_reg <= S_READ;
              `PFC_CMD_RESET: begin
                state_reg <= S_RESET;
                rst_cnt_reg <= 8'h00;
              end
              `PFC_CMD_WRITE: begin
                if (!sw_wdata_i[`PFC_CTRL_GUARD_BIT]) refused_reg <= 1'b1;
                else begin
                  state_reg <= S_SETUP;
                  if (one_strobe_reg) step_reg <= 3'h5;
                  else step_reg <= 3'h0;
                end
              end
              `PFC_CMD_CHIP_ERASE, `PFC_CMD_SECT_ERASE: begin
                if (!sw_wdata_i[`PFC_CTRL_GUARD_BIT] || one_strobe_reg) refused_reg <= 1'b1;
                else state_reg <= S_SETUP;
              end
              `PFC_CMD_ONE_STROBE: begin
                if (one_strobe_reg || !sw_wdata_i[`PFC_CTRL_GUARD_BIT]) refused_reg <= 1'b1;
                else state_reg <= S_SETUP;
              end
              default: refused_reg <= 1'b1;
            endcase
          end
        end
        S_SETUP: begin
          fl_oe_n_o <= 1'b1;
          fl_ce_n_o <= 1'b0;
          fl_dq_oe_o <= 1'b1;
          if (step_reg == 3'h5 && cmd_reg == `PFC_CMD_SECT_ERASE)
            fl_addr_o <= {sect_reg, 14'h0000};
          else if (step_reg == 3'h5 && cmd_reg == `PFC_CMD_WRITE)
            fl_addr_o <= addr_reg;
          else if (step_reg == 3'h3 && cmd_reg == `PFC_CMD_WRITE)
            fl_addr_o <= addr_reg;
          else
            fl_addr_o <= rom_addr;
          if (cmd_reg == `PFC_CMD_WRITE && (step_reg == 3'h3 || step_reg == 3'h5))
            fl_dq_o <= fit_width(wdata_reg, width_reg);
          else
            fl_dq_o <= {8'h00, rom_data};
          phase_reg <= phase_reg + 4'h1;
          if (phase_reg == `PFC_PHASE_CYC) begin
            phase_reg <= 4'h0;
            fl_we_n_o <= 1'b0;
            state_reg <= S_STROBE;
          end
        end
        S_STROBE: begin
          phase_reg <= phase_reg + 4'h1;
          if (phase_reg == `PFC_PHASE_CYC) begin
            phase_reg <= 4'h0;
            fl_we_n_o <= 1'b1;
            state_reg <= S_HOLD;
          end
        end
        S_HOLD: begin
          phase_reg <= phase_reg + 4'h1;
          if (phase_reg == `PFC_PHASE_CYC) begin
            phase_reg <= 4'h0;
            fl_ce_n_o <= 1'b1;
            fl_dq_oe_o <= 1'b0;
            if (step_reg == 3'h3 && cmd_reg == `PFC_CMD_WRITE) step_reg <= 3'h6;
            else step_reg <= step_reg + 3'h1;
            if (step_reg == 3'h5 || step_reg + 3'h1 == rom_len) begin
              if (cmd_reg == `PFC_CMD_ONE_STROBE) begin
                one_strobe_reg <= 1'b1;
                state_reg <= S_IDLE;
              end else begin
                erasing_reg <= (cmd_reg != `PFC_CMD_WRITE);
                state_reg <= S_POLL;
              end
            end else begin
              state_reg <= S_SETUP;
            end
          end
        end
        S_POLL: begin
          fl_addr_o <= (cmd_reg == `PFC_CMD_SECT_ERASE) ? {sect_reg, 14'h0000} : addr_reg;
          fl_ce_n_o <= 1'b0;
          fl_oe_n_o <= 1'b0;
          phase_reg <= phase_reg + 4'h1;
          if (phase_reg == `PFC_PHASE_CYC + `PFC_PHASE_CYC) begin
            phase_reg <= 4'h0;
            fl_oe_n_o <= 1'b1;
            rdata_reg <= fit_width(dq_s2_reg, width_reg);
            // locked sector ends at once, bit seven then reads one
            if (dq_s2_reg[`PFC_POLL_BIT] || cmd_reg == `PFC_CMD_WRITE) begin
              erasing_reg <= 1'b0;
              state_reg <= S_IDLE;
            end
          end
        end
        S_READ: begin
          fl_addr_o <= addr_reg;
          fl_we_n_o <= 1'b1;
          fl_dq_oe_o <= 1'b0;
          fl_ce_n_o <= 1'b0;
          fl_oe_n_o <= 1'b0;
          phase_reg <= phase_reg + 4'h1;
          if (phase_reg == `PFC_PHASE_CYC + `PFC_PHASE_CYC) begin
            rdata_reg <= fit_width(dq_s2_reg, width_reg);
            fl_ce_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            phase_reg <= 4'h0;
            state_reg <= S_IDLE;
          end
        end
        S_RESET: begin
          fl_ce_n_o <= 1'b1;
          fl_oe_n_o <= 1'b1;
          fl_we_n_o <= 1'b1;
          fl_dq_oe_o <= 1'b0;
          rst_cnt_reg <= rst_cnt_reg + 8'h01;
          if (rst_cnt_reg == RESET_CYC) begin
            one_strobe_reg <= 1'b0;
            erasing_reg <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // pfc_ctrl
`default_nettype wire

// >>> tb/pfc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_ctrl_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // flash pins
  input wire logic [20:0] fl_addr_o,
  input wire logic [15:0] fl_dq_o,
  input wire logic fl_dq_oe_o,
  input wire logic fl_ce_n_o,
  input wire logic fl_oe_n_o,
  input wire logic fl_we_n_o,
  input wire logic fl_reset_n_o,
  input wire logic fl_vpp_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  a_we_under_ce: assert property (!fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o)
    else $error("write strobe outside select");
  a_we_pulse_len: assert property ($fell(fl_we_n_o) |-> !fl_we_n_o [*3] ##1 fl_we_n_o)
    else $error("write strobe length wrong");
  a_addr_steady: assert property (!fl_we_n_o |-> $stable(fl_addr_o) && fl_dq_oe_o)
    else $error("address moved under write strobe");
  a_data_held: assert property (!fl_we_n_o ##1 fl_we_n_o |-> fl_dq_oe_o && !fl_ce_n_o && $stable(fl_dq_o))
    else $error("data not held past strobe rise");
  a_no_contend: assert property (!fl_oe_n_o |-> !fl_dq_oe_o && fl_we_n_o)
    else $error("host drives data during read");
  a_guard_blocks: assert property (!fl_vpp_en_o |-> fl_we_n_o)
    else $error("write cycle with guard low");
  a_reset_width: assert property ($fell(fl_reset_n_o) |-> !fl_reset_n_o [*5])
    else $error("reset pulse too short");
  a_reset_quiet: assert property (!fl_reset_n_o |-> fl_ce_n_o && fl_we_n_o && fl_oe_n_o && !fl_dq_oe_o)
    else $error("bus active during reset");
endmodule // pfc_ctrl_asserts
bind pfc_ctrl pfc_ctrl_asserts i_pfc_ctrl_asserts (.clk_i(clk_i), .arst_n_i(arst_n_i), .fl_addr_o(fl_addr_o),
  .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o), .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o),
  .fl_we_n_o(fl_we_n_o), .fl_reset_n_o(fl_reset_n_o), .fl_vpp_en_o(fl_vpp_en_o));
`default_nettype wire

// >>> tb/pfc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_flash_model (
  // host side pins
  input wire logic [20:0] addr_i,
  input wire logic [15:0] dq_h_i,
  input wire logic dq_oe_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic rst_n_i,
  input wire logic byte_i,
  input wire logic vpp_i,
  // resolved data lines
  output logic [15:0] dq_o
);
  logic [15:0] mem[int];
  logic [15:0] rv = 16'hFFFF;
  logic [20:0] a_lat = 21'h000000;
  logic [7:0] c;
  logic flt = 0;
  logic one = 0;
  logic pgm = 0;
  logic erasing = 0;
  int st = 0;
  realtime rst_t = 0;
  function automatic logic [15:0] val(input logic [20:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  always #50 flt = ~flt;
  wire drv = !ce_n_i && !oe_n_i && we_n_i && rst_n_i;
  wire [15:0] fl = {8{flt, ~flt}};
  always @(negedge oe_n_i, addr_i, erasing) rv = erasing ? 16'h0000 : val(addr_i);
  assign dq_o = dq_oe_i ? dq_h_i : !drv ? fl : {byte_i ? rv[15:8] : fl[15:8], rv[7:0]};
  always @(posedge erasing) #4000 erasing = 0;
  always @(negedge we_n_i) if (!ce_n_i) a_lat = addr_i;
  always @(posedge we_n_i) if (!ce_n_i && oe_n_i && rst_n_i && !erasing) begin
    c = dq_h_i[7:0];
    if (one || pgm) begin
      if (vpp_i) mem[a_lat] = val(a_lat) & dq_h_i;
      pgm = 0;
    end else if (st == 0 || st == 3) begin
      st = (c == 8'hAA && a_lat[10:0] == 11'h555) ? st + 1 : 0;
    end else if (st == 1 || st == 4) begin
      st = (c == 8'h55 && a_lat[10:0] == 11'h2AA) ? st + 1 : 0;
    end else if (st == 2) begin
      pgm = c == 8'hA0;
      st = c == 8'h80 ? 3 : 0;
    end else begin
      st = 0;
      if (vpp_i && c == 8'hA0) one = 1;
      if (vpp_i && c == 8'h10) mem.delete();
      if (vpp_i && c == 8'h30) foreach (mem[k]) if (k[20:14] == a_lat[20:14]) mem[k] = 16'hFFFF;
      erasing = vpp_i && (c == 8'h10 || c == 8'h30);
    end
  end
  always @(negedge rst_n_i) begin
    rst_t = $realtime;
    erasing = 0;
    st = 0;
    pgm = 0;
  end
  always @(posedge rst_n_i) if ($realtime - rst_t >= 500) one = 0;
endmodule // pfc_flash_model
`default_nettype wire

// >>> tb/tb_pfc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.vh"
`define CHK(n, e, g) begin samples_checked++; if ((e) !== (g)) begin errors++; $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_pfc_ctrl;
  logic clk_i = 0;
  logic arst_n_i = 0;
  logic sw_we_i = 0;
  logic sw_re_i = 0;
  logic re_d = 0;
  logic wide = 1;
  logic [3:0] sw_addr_i = 4'h0;
  logic [31:0] sw_wdata_i = 32'h0;
  logic [31:0] sw_rdata_o, got, me, mm;
  logic [20:0] fl_addr_o, a1, a2;
  logic [15:0] fl_dq_i, fl_dq_o, d1, d2;
  logic fl_dq_oe_o, fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_reset_n_o, fl_byte_o, fl_vpp_en_o;
  logic [31:0] exp_q[$], msk_q[$];
  integer errors = 0, samples_checked = 0, seed = 69677;
  initial forever #50 clk_i = ~clk_i;
  pfc_ctrl i_pfc_ctrl (.clk_i(clk_i), .arst_n_i(arst_n_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i),
    .sw_we_i(sw_we_i), .sw_re_i(sw_re_i), .sw_rdata_o(sw_rdata_o), .fl_addr_o(fl_addr_o), .fl_dq_i(fl_dq_i),
    .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o), .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o),
    .fl_we_n_o(fl_we_n_o), .fl_reset_n_o(fl_reset_n_o), .fl_byte_o(fl_byte_o), .fl_vpp_en_o(fl_vpp_en_o));
  pfc_flash_model i_pfc_flash_model (.addr_i(fl_addr_o), .dq_h_i(fl_dq_o), .dq_oe_i(fl_dq_oe_o),
    .ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o), .rst_n_i(fl_reset_n_o), .byte_i(fl_byte_o),
    .vpp_i(fl_vpp_en_o), .dq_o(fl_dq_i));
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_we_i <= 1;
    @(posedge clk_i);
    sw_we_i <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk_i);
    sw_addr_i <= a;
    sw_re_i <= 1;
    @(posedge clk_i);
    sw_re_i <= 0;
    #1 got = sw_rdata_o;
  endtask
  task automatic cmd(input logic [3:0] c, input logic g);
    int n;
    wr(`PFC_REG_CTRL, {22'h0, g, wide, 4'h0, c});
    n = 0;
    got = 32'h1;
    while (got[`PFC_STAT_BUSY_BIT] !== 1'b0 && n < 3000) begin
      rd(`PFC_REG_STAT, 32'h0, 32'h0);
      n++;
    end
    if (n >= 3000) errors++;
  endtask
  task automatic prog(input logic [20:0] a, input logic [15:0] d);
    wr(`PFC_REG_ADDR, {11'h0, a});
    wr(`PFC_REG_WDATA, {16'h0, d});
    cmd(`PFC_CMD_WRITE, 1);
  endtask
  task automatic look(input logic [20:0] a, input logic [15:0] e);
    wr(`PFC_REG_ADDR, {11'h0, a});
    cmd(`PFC_CMD_READ, 1);
    rd(`PFC_REG_RDATA, {16'h0, e}, 32'hFFFF);
  endtask
  task automatic results;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (re_d) begin
      me = exp_q.pop_front();
      mm = msk_q.pop_front();
      if (mm != 0) `CHK("sw_rdata_o", me & mm, sw_rdata_o & mm)
    end
    re_d <= sw_re_i;
  end
  initial begin
    #3000000;
    errors++;
    results;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1;
    a1 = $random(seed) & 21'h0FFFFF;
    a2 = a1 ^ 21'h004000;
    d1 = $random(seed);
    d2 = $random(seed);
    rd(`PFC_REG_STAT, 32'h0, 32'hF);
    rd(4'hF, 32'h0, 32'hFFFFFFFF);
    look(a1, 16'hFFFF);
    wr(`PFC_REG_ADDR, {11'h0, a1});
    wr(`PFC_REG_WDATA, {16'h0, d1});
    cmd(`PFC_CMD_WRITE, 0);
    rd(`PFC_REG_STAT, 32'h8, 32'h8);
    look(a1, 16'hFFFF);
    prog(a1, d1);
    look(a1, d1);
    prog(a1, d2);
    look(a1, d1 & d2);
    prog(a2, d1);
    wr(`PFC_REG_SECT, {25'h0, a1[20:14]});
    wr(`PFC_REG_SECT, 32'h00000047);
    rd(`PFC_REG_SECT, {25'h0, a1[20:14]}, 32'h7F);
    cmd(`PFC_CMD_SECT_ERASE, 1);
    look(a1, 16'hFFFF);
    look(a2, d1);
    wr(`PFC_REG_CTRL, {22'h0, 1'b1, 1'b1, 4'h0, `PFC_CMD_CHIP_ERASE});
    repeat (60) @(posedge clk_i);
    rd(`PFC_REG_STAT, 32'h5, 32'h5);
    cmd(`PFC_CMD_READ, 1);
    look(a2, 16'hFFFF);
    cmd(`PFC_CMD_ONE_STROBE, 1);
    rd(`PFC_REG_STAT, 32'h2, 32'h2);
    prog(a1, d2);
    look(a1, d2);
    cmd(`PFC_CMD_SECT_ERASE, 1);
    rd(`PFC_REG_STAT, 32'hA, 32'hA);
    look(a1, d2);
    cmd(`PFC_CMD_RESET, 1);
    rd(`PFC_REG_STAT, 32'h0, 32'h2);
    prog(a2, d1);
    look(a2, d1);
    wide = 0;
    look(a2, {8'h00, d1[7:0]});
    repeat (3) @(posedge clk_i);
    results;
  end
endmodule // tb_pfc_ctrl
`default_nettype wire
